//--- src/duc_top.v
// Dual serial channel with host strobe port, modem pins and data FIFOs.
`timescale 1ns/10ps
`include "duc_defines.vh"

// ****************************************
// Data FIFO
// ****************************************
module duc_fifo #(
   parameter WIDTH = 8,
   parameter DEPTH = `DUC_FIFO_DEPTH,
   parameter AW = 4
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire in_valid_i,
   output wire in_ready_o,
   input wire [WIDTH-1:0] in_data_i,
   output wire out_valid_o,
   input wire out_ready_i,
   output wire [WIDTH-1:0] out_data_o,
   output wire [AW:0] level_o
);
   localparam [AW:0] FULL = DEPTH;
   reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
   reg [AW-1:0] wr_reg;
   reg [AW-1:0] rd_reg;
   reg [AW:0] count_reg;
   wire push = in_valid_i & in_ready_o;
   wire pop = out_valid_o & out_ready_i;
   assign in_ready_o = (count_reg != FULL);
   assign out_valid_o = (count_reg != {(AW+1){1'b0}});
   assign out_data_o = mem_reg[rd_reg];
   assign level_o = count_reg;
   always @(posedge clk_i) begin
      if (push) begin
         mem_reg[wr_reg] <= in_data_i;
      end
   end
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         wr_reg <= {AW{1'b0}};
         rd_reg <= {AW{1'b0}};
         count_reg <= {(AW+1){1'b0}};
      end else begin
         if (push) wr_reg <= wr_reg + 1'b1;
         if (pop) rd_reg <= rd_reg + 1'b1;
         if (push && !pop) count_reg <= count_reg + 1'b1;
         else if (pop && !push) count_reg <= count_reg - 1'b1;
      end
   end
endmodule // duc_fifo

// ****************************************
// One serial channel
// ****************************************
module duc_chan #(
   parameter BAUD = 868,
   parameter TMO = 34720
) (
   input wire clk_i,
   input wire rst_n_i,
   input wire rd_i,
   input wire wr_i,
   input wire [2:0] addr_i,
   input wire [7:0] wdata_i,
   output reg [7:0] rdata_o,
   input wire rx_i,
   input wire cts_n_i,
   input wire dsr_n_i,
   input wire ri_n_i,
   input wire cd_n_i,
   output reg tx_o,
   output reg dtr_n_o,
   output reg rts_n_o,
   output reg op_n_o,
   output reg irq_o,
   output reg irq_oe_n_o,
   output reg rx_dma_request_n_n_o,
   output reg tx_dma_request_n_n_o
);
   localparam [1:0] TX_IDLE = 2'b00;
   localparam [1:0] TX_SHIFT = 2'b01;
   localparam [1:0] RX_IDLE = 2'b00;
   localparam [1:0] RX_BITS = 2'b01;
   localparam [4:0] FULL = `DUC_FIFO_DEPTH;
   reg [7:0] ier_reg, efr_reg, trig_reg, mcr_reg, flow_reg;
   reg [3:0] delta_reg;
   reg [3:0] modem_prev_reg;
   reg ovr_reg, frm_reg;
   reg [1:0] tx_state_reg, rx_state_reg;
   reg [9:0] tx_shift_reg;
   reg [3:0] tx_bit_reg, rx_bit_reg;
   reg [15:0] tx_cnt_reg, rx_cnt_reg;
   reg [8:0] rx_shift_reg;
   reg [31:0] tmo_cnt_reg;
   reg tmo_reg, hold_reg, rx_push_reg;
   reg [7:0] rx_byte_reg;
   wire tx_valid, rx_valid, rx_in_ready;
   wire [7:0] tx_data, rx_data;
   wire [4:0] tx_level, rx_level;
   wire wr_data = wr_i && (addr_i == `DUC_OFS_DATA);
   wire rd_data = rd_i && (addr_i == `DUC_OFS_DATA);
   wire loop = mcr_reg[`DUC_MCR_LOOP];
   wire rx_line = loop ? tx_shift_reg[0] | (tx_state_reg == TX_IDLE) : rx_i;
   wire cts_ok = !efr_reg[`DUC_EFR_ACTS] || !cts_n_i;
   wire tx_take = (tx_state_reg == TX_IDLE) && cts_ok;
   wire [3:0] modem_now = {~cd_n_i, ~ri_n_i, ~dsr_n_i, ~cts_n_i};
   wire [7:0] modem_status_register = {modem_now, delta_reg};
   wire line_err = ovr_reg | frm_reg;
   wire [7:0] lsr = {1'b0, (tx_level == 5'd0) && (tx_state_reg == TX_IDLE),
      tx_level == 5'd0, 1'b0, frm_reg, 1'b0, ovr_reg, rx_valid};
   wire [4:0] rx_trig = (trig_reg[3:0] == 4'h0) ? 5'd1 : {1'b0, trig_reg[3:0]};
   wire [4:0] tx_trig = (trig_reg[7:4] == 4'h0) ? 5'd1 : {1'b0, trig_reg[7:4]};
   wire irq_src = (ier_reg[`DUC_IER_RX] && (rx_valid || tmo_reg)) ||
      (ier_reg[`DUC_IER_TX] && tx_level == 5'd0) ||
      (ier_reg[`DUC_IER_LS] && line_err) ||
      (ier_reg[`DUC_IER_MS] && delta_reg != 4'h0);

   duc_fifo #(.WIDTH(8), .DEPTH(`DUC_FIFO_DEPTH), .AW(4)) u_tx_fifo (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .in_valid_i(wr_data), .in_ready_o(), .in_data_i(wdata_i),
      .out_valid_o(tx_valid), .out_ready_i(tx_take), .out_data_o(tx_data),
      .level_o(tx_level));
   duc_fifo #(.WIDTH(8), .DEPTH(`DUC_FIFO_DEPTH), .AW(4)) u_rx_fifo (
      .clk_i(clk_i), .rst_n_i(rst_n_i),
      .in_valid_i(rx_push_reg), .in_ready_o(rx_in_ready), .in_data_i(rx_byte_reg),
      .out_valid_o(rx_valid), .out_ready_i(rd_data), .out_data_o(rx_data),
      .level_o(rx_level));

   always @* begin
      case (addr_i)
         `DUC_OFS_DATA: rdata_o = rx_valid ? rx_data : `DUC_RST_REG;
         `DUC_OFS_IER: rdata_o = ier_reg;
         `DUC_OFS_EFR: rdata_o = efr_reg;
         `DUC_OFS_TRIG: rdata_o = trig_reg;
         `DUC_OFS_MCR: rdata_o = mcr_reg;
         `DUC_OFS_LSR: rdata_o = lsr;
         `DUC_OFS_MSR: rdata_o = modem_status_register;
         default: rdata_o = flow_reg;
      endcase
   end

   // ****************************************
   // Registers and modem pins
   // ****************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         ier_reg <= `DUC_RST_REG;
         efr_reg <= `DUC_RST_REG;
         trig_reg <= `DUC_RST_TRIG;
         mcr_reg <= `DUC_RST_REG;
         flow_reg <= `DUC_RST_REG;
         delta_reg <= 4'h0;
         modem_prev_reg <= 4'h0;
         ovr_reg <= 1'b0;
         frm_reg <= 1'b0;
         hold_reg <= 1'b0;
         dtr_n_o <= 1'b1;
         rts_n_o <= 1'b1;
         op_n_o <= 1'b1;
         irq_o <= 1'b0;
         irq_oe_n_o <= 1'b1;
         rx_dma_request_n_n_o <= 1'b1;
         tx_dma_request_n_n_o <= 1'b1;
      end else begin
         if (wr_i) begin
            case (addr_i)
               `DUC_OFS_IER: ier_reg <= wdata_i;
               `DUC_OFS_EFR: efr_reg <= wdata_i;
               `DUC_OFS_TRIG: trig_reg <= wdata_i;
               `DUC_OFS_MCR: mcr_reg <= wdata_i;
               `DUC_OFS_FLOW: flow_reg <= wdata_i;
               default: ;
            endcase
         end
         modem_prev_reg <= modem_now;
         delta_reg <= ((rd_i && addr_i == `DUC_OFS_MSR) ? 4'h0 : delta_reg) |
            {modem_now[3] ^ modem_prev_reg[3], modem_prev_reg[2] & ~modem_now[2],
             modem_now[1:0] ^ modem_prev_reg[1:0]};
         if (rd_i && addr_i == `DUC_OFS_LSR) begin
            ovr_reg <= 1'b0;
            frm_reg <= 1'b0;
         end
         if (rx_push_reg && !rx_in_ready) ovr_reg <= 1'b1;
         if (rx_state_reg == RX_BITS && rx_cnt_reg == 16'd0 && rx_bit_reg == 4'd9 &&
             !rx_line) frm_reg <= 1'b1;
         if (flow_reg[3:0] != 4'h0 && rx_level >= {1'b0, flow_reg[3:0]}) hold_reg <= 1'b1;
         else if (rx_level <= {1'b0, flow_reg[7:4]}) hold_reg <= 1'b0;
         dtr_n_o <= ~mcr_reg[`DUC_MCR_DTR];
         rts_n_o <= ~(mcr_reg[`DUC_MCR_RTS] && !(efr_reg[`DUC_EFR_ARTS] && hold_reg));
         op_n_o <= ~mcr_reg[`DUC_MCR_OUT];
         irq_oe_n_o <= ~mcr_reg[`DUC_MCR_OUT];
         irq_o <= mcr_reg[`DUC_MCR_OUT] && irq_src;
         if (rx_level == 5'd0 || line_err) rx_dma_request_n_n_o <= 1'b1;
         else if (rx_level >= rx_trig || tmo_reg) rx_dma_request_n_n_o <= 1'b0;
         if (tx_level == FULL) tx_dma_request_n_n_o <= 1'b1;
         else if (FULL - tx_level >= tx_trig) tx_dma_request_n_n_o <= 1'b0;
      end
   end

   // ****************************************
   // Transmitter
   // ****************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tx_state_reg <= TX_IDLE;
         tx_shift_reg <= 10'h3ff;
         tx_bit_reg <= 4'd0;
         tx_cnt_reg <= 16'd0;
         tx_o <= 1'b1;
      end else begin
         tx_o <= loop ? 1'b1 : tx_shift_reg[0];
         case (tx_state_reg)
            TX_IDLE: begin
               if (tx_valid && cts_ok) begin
                  tx_shift_reg <= {1'b1, tx_data, 1'b0};
                  tx_bit_reg <= 4'd0;
                  tx_cnt_reg <= BAUD[15:0] - 16'd1;
                  tx_state_reg <= TX_SHIFT;
               end
            end
            TX_SHIFT: begin
               if (tx_cnt_reg != 16'd0) begin
                  tx_cnt_reg <= tx_cnt_reg - 16'd1;
               end else begin
                  tx_cnt_reg <= BAUD[15:0] - 16'd1;
                  tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
                  tx_bit_reg <= tx_bit_reg + 4'd1;
                  if (tx_bit_reg == 4'd9) tx_state_reg <= TX_IDLE;
               end
            end
            default: tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // ****************************************
   // Receiver and timeout
   // ****************************************
   always @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rx_state_reg <= RX_IDLE;
         rx_shift_reg <= 9'h000;
         rx_bit_reg <= 4'd0;
         rx_cnt_reg <= 16'd0;
         rx_push_reg <= 1'b0;
         rx_byte_reg <= `DUC_RST_REG;
         tmo_cnt_reg <= 32'd0;
         tmo_reg <= 1'b0;
      end else begin
         rx_push_reg <= 1'b0;
         case (rx_state_reg)
            RX_IDLE: begin
               if (!rx_line) begin
                  rx_cnt_reg <= BAUD[16:1];
                  rx_bit_reg <= 4'd0;
                  rx_state_reg <= RX_BITS;
               end
            end
            RX_BITS: begin
               if (rx_cnt_reg != 16'd0) begin
                  rx_cnt_reg <= rx_cnt_reg - 16'd1;
               end else begin
                  rx_cnt_reg <= BAUD[15:0] - 16'd1;
                  rx_bit_reg <= rx_bit_reg + 4'd1;
                  rx_shift_reg <= {rx_line, rx_shift_reg[8:1]};
                  if (rx_bit_reg == 4'd0 && rx_line) rx_state_reg <= RX_IDLE;
                  if (rx_bit_reg == 4'd9) begin
                     rx_byte_reg <= rx_shift_reg[8:1];
                     rx_push_reg <= 1'b1;
                     rx_state_reg <= RX_IDLE;
                  end
               end
            end
            default: rx_state_reg <= RX_IDLE;
         endcase
         if (!rx_valid || rx_push_reg || rd_data) begin
            tmo_cnt_reg <= 32'd0;
            tmo_reg <= 1'b0;
         end else if (tmo_cnt_reg == TMO) begin
            tmo_reg <= 1'b1;
         end else begin
            tmo_cnt_reg <= tmo_cnt_reg + 32'd1;
         end
      end
   end
endmodule // duc_chan

// ****************************************
// Top level
// ****************************************
module duc_top #(
   parameter BAUD_CYCLES = `DUC_BIT_NS / `DUC_CLK_NS,
   parameter RX_TIMEOUT_CYCLES = `DUC_TMO_CHARS * `DUC_CHAR_BITS * BAUD_CYCLES
) (
   input wire CLK_I,
   input wire RESETN_I,
   input wire READ_STROBE_N_I,
   input wire WRITE_STROBE_N_I,
   input wire CHIP_SELECT_CH0_N_I,
   input wire CHIP_SELECT_CH1_N_I,
   input wire [2:0] REG_SELECT_LINES_I,
   input wire [7:0] HOST_DATA_BUS_I,
   output reg [7:0] HOST_DATA_BUS_O,
   output reg HOST_DATA_BUS_OE_N_O,
   input wire [1:0] RX_I,
   input wire [1:0] CTS_N_I,
   input wire [1:0] DSR_N_I,
   input wire [1:0] RI_N_I,
   input wire [1:0] CD_N_I,
   output wire [1:0] TX_O,
   output wire [1:0] DTR_N_O,
   output wire [1:0] RTS_N_O,
   output wire USER_OUTPUT_CH0_N_O,
   output wire USER_OUTPUT_CH1_N_O,
   output wire IRQ_CH0_O,
   output wire IRQ_CH0_OE_N_O,
   output wire IRQ_CH1_O,
   output wire IRQ_CH1_OE_N_O,
   output wire [1:0] RX_DMA_REQUEST_N_O,
   output wire [1:0] TX_DMA_REQUEST_N_O
);
   localparam N = 25;
   reg [1:0] rst_sync_reg;
   reg [N-1:0] s1_reg, s2_reg, s3_reg, filt_reg;
   reg rd_prev_reg, wr_prev_reg;
   wire rst_n = rst_sync_reg[1];
   wire [N-1:0] pins = {CD_N_I, RI_N_I, DSR_N_I, CTS_N_I, RX_I, HOST_DATA_BUS_I,
      REG_SELECT_LINES_I, CHIP_SELECT_CH1_N_I, CHIP_SELECT_CH0_N_I,
      WRITE_STROBE_N_I, READ_STROBE_N_I};
   wire rd_n = filt_reg[0];
   wire wr_n = filt_reg[1];
   wire [1:0] cs_n = filt_reg[3:2];
   wire [2:0] addr = filt_reg[6:4];
   wire [7:0] wdata = filt_reg[14:7];
   wire rd_fall = rd_prev_reg && !rd_n;
   wire wr_rise = !wr_prev_reg && wr_n;
   wire [7:0] rdata0, rdata1;
   wire [1:0] op_n, irq, irq_oe_n;

   always @(posedge CLK_I or negedge RESETN_I) begin
      if (!RESETN_I) rst_sync_reg <= 2'b00;
      else rst_sync_reg <= {rst_sync_reg[0], 1'b1};
   end

   always @(posedge CLK_I or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg <= {N{1'b1}};
         s2_reg <= {N{1'b1}};
         s3_reg <= {N{1'b1}};
         filt_reg <= {N{1'b1}};
         rd_prev_reg <= 1'b1;
         wr_prev_reg <= 1'b1;
         HOST_DATA_BUS_O <= 8'h00;
         HOST_DATA_BUS_OE_N_O <= 1'b1;
      end else begin
         s1_reg <= pins;
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
         filt_reg <= (s2_reg & s3_reg) | (filt_reg & (s2_reg ^ s3_reg));
         rd_prev_reg <= rd_n;
         wr_prev_reg <= wr_n;
         if (rd_fall && cs_n != 2'b11) begin
            HOST_DATA_BUS_O <= !cs_n[0] ? rdata0 : rdata1;
            HOST_DATA_BUS_OE_N_O <= 1'b0;
         end else if (rd_n) begin
            HOST_DATA_BUS_OE_N_O <= 1'b1;
         end
      end
   end

   duc_chan #(.BAUD(BAUD_CYCLES), .TMO(RX_TIMEOUT_CYCLES)) u_ch0 (
      .clk_i(CLK_I), .rst_n_i(rst_n),
      .rd_i(rd_fall && !cs_n[0]), .wr_i(wr_rise && !cs_n[0]),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata0),
      .rx_i(filt_reg[15]), .cts_n_i(filt_reg[17]), .dsr_n_i(filt_reg[19]),
      .ri_n_i(filt_reg[21]), .cd_n_i(filt_reg[23]),
      .tx_o(TX_O[0]), .dtr_n_o(DTR_N_O[0]), .rts_n_o(RTS_N_O[0]),
      .op_n_o(op_n[0]), .irq_o(irq[0]), .irq_oe_n_o(irq_oe_n[0]),
      .rx_dma_request_n_n_o(RX_DMA_REQUEST_N_O[0]), .tx_dma_request_n_n_o(TX_DMA_REQUEST_N_O[0]));
   duc_chan #(.BAUD(BAUD_CYCLES), .TMO(RX_TIMEOUT_CYCLES)) u_ch1 (
      .clk_i(CLK_I), .rst_n_i(rst_n),
      .rd_i(rd_fall && !cs_n[1]), .wr_i(wr_rise && !cs_n[1]),
      .addr_i(addr), .wdata_i(wdata), .rdata_o(rdata1),
      .rx_i(filt_reg[16]), .cts_n_i(filt_reg[18]), .dsr_n_i(filt_reg[20]),
      .ri_n_i(filt_reg[22]), .cd_n_i(filt_reg[24]),
      .tx_o(TX_O[1]), .dtr_n_o(DTR_N_O[1]), .rts_n_o(RTS_N_O[1]),
      .op_n_o(op_n[1]), .irq_o(irq[1]), .irq_oe_n_o(irq_oe_n[1]),
      .rx_dma_request_n_n_o(RX_DMA_REQUEST_N_O[1]), .tx_dma_request_n_n_o(TX_DMA_REQUEST_N_O[1]));

   assign USER_OUTPUT_CH0_N_O = op_n[0];
   assign USER_OUTPUT_CH1_N_O = op_n[1];
   assign IRQ_CH0_O = irq[0];
   assign IRQ_CH1_O = irq[1];
   assign IRQ_CH0_OE_N_O = irq_oe_n[0];
   assign IRQ_CH1_OE_N_O = irq_oe_n[1];
endmodule // duc_top

//--- src/duc_defines.vh
// Constants for the dual serial channel pin interface.
`ifndef DUC_DEFINES_VH
`define DUC_DEFINES_VH
// ****************************************
// Register offsets on the select lines
// ****************************************
`define DUC_OFS_DATA 3'h0
`define DUC_OFS_IER 3'h1
`define DUC_OFS_EFR 3'h2
`define DUC_OFS_TRIG 3'h3
`define DUC_OFS_MCR 3'h4
`define DUC_OFS_LSR 3'h5
`define DUC_OFS_MSR 3'h6
`define DUC_OFS_FLOW 3'h7
// ****************************************
// Field positions
// ****************************************
`define DUC_MCR_DTR 0
`define DUC_MCR_RTS 1
`define DUC_MCR_OUT 3
`define DUC_MCR_LOOP 4
`define DUC_EFR_ARTS 6
`define DUC_EFR_ACTS 7
`define DUC_IER_RX 0
`define DUC_IER_TX 1
`define DUC_IER_LS 2
`define DUC_IER_MS 3
`define DUC_MSR_DCTS 0
`define DUC_MSR_DDSR 1
`define DUC_MSR_TERI 2
`define DUC_MSR_DCD 3
`define DUC_MSR_CTS 4
`define DUC_MSR_DSR 5
`define DUC_MSR_RI 6
`define DUC_MSR_CD 7
// ****************************************
// Reset values and timing
// ****************************************
`define DUC_RST_REG 8'h00
`define DUC_RST_TRIG 8'h11
`define DUC_FIFO_DEPTH 16
`define DUC_CLK_NS 10
`define DUC_BIT_NS 8680
`define DUC_CHAR_BITS 10
`define DUC_TMO_CHARS 4
`endif

//--- src/duc_fifo_unused_placeholder.v
`timescale 1ns/10ps

//--- bench/duc_top_props.sv
// Assertion checker for the dual serial channel top level.
`timescale 1ns/10ps
module duc_top_props (
   input wire CLK_I,
   input wire RESETN_I,
   input wire READ_STROBE_N_I,
   input wire WRITE_STROBE_N_I,
   input wire CHIP_SELECT_CH0_N_I,
   input wire CHIP_SELECT_CH1_N_I,
   input wire HOST_DATA_BUS_OE_N_O,
   input wire [1:0] TX_O,
   input wire [1:0] DTR_N_O,
   input wire [1:0] RTS_N_O,
   input wire USER_OUTPUT_CH0_N_O,
   input wire USER_OUTPUT_CH1_N_O,
   input wire IRQ_CH0_O,
   input wire IRQ_CH0_OE_N_O,
   input wire IRQ_CH1_O,
   input wire IRQ_CH1_OE_N_O,
   input wire [1:0] RX_DMA_REQUEST_N_O,
   input wire [1:0] TX_DMA_REQUEST_N_O
);
   reg [1:0] rst_age = 2'h0;
   reg [3:0] wr_age = 4'hF;
   reg wr_prev = 1'b1;
   // ****************************************
   // Helper counters
   // ****************************************
   always @(posedge CLK_I) begin
      rst_age <= RESETN_I ? 2'h0 : ((rst_age == 2'h3) ? rst_age : rst_age + 2'h1);
      wr_prev <= WRITE_STROBE_N_I;
      if (WRITE_STROBE_N_I && !wr_prev) begin
         wr_age <= 4'h0;
      end else begin
         wr_age <= (wr_age == 4'hF) ? wr_age : wr_age + 4'h1;
      end
   end
   default clocking cb @(posedge CLK_I); endclocking
   default disable iff (!RESETN_I);
   // ****************************************
   // Properties
   // ****************************************
   property p_reset_out;
      disable iff (1'b0) (rst_age >= 2'h2) |-> (TX_O == 2'h3) && (DTR_N_O == 2'h3)
         && (RTS_N_O == 2'h3) && USER_OUTPUT_CH0_N_O && USER_OUTPUT_CH1_N_O
         && HOST_DATA_BUS_OE_N_O && IRQ_CH0_OE_N_O && IRQ_CH1_OE_N_O && !IRQ_CH0_O
         && !IRQ_CH1_O && (RX_DMA_REQUEST_N_O == 2'h3) && (TX_DMA_REQUEST_N_O == 2'h3);
   endproperty
   property p_user0;
      USER_OUTPUT_CH0_N_O == IRQ_CH0_OE_N_O;
   endproperty
   property p_user1;
      USER_OUTPUT_CH1_N_O == IRQ_CH1_OE_N_O;
   endproperty
   property p_irq0;
      IRQ_CH0_OE_N_O |-> !IRQ_CH0_O;
   endproperty
   property p_irq1;
      IRQ_CH1_OE_N_O |-> !IRQ_CH1_O;
   endproperty
   property p_rd_start;
      $fell(HOST_DATA_BUS_OE_N_O) |-> !$past(READ_STROBE_N_I, 3)
         && !($past(CHIP_SELECT_CH0_N_I, 3) && $past(CHIP_SELECT_CH1_N_I, 3));
   endproperty
   property p_rd_end;
      $rose(READ_STROBE_N_I) |-> ##[1:7] HOST_DATA_BUS_OE_N_O;
   endproperty
   property p_ctl_src;
      $changed(DTR_N_O) || $changed(USER_OUTPUT_CH0_N_O) || $changed(USER_OUTPUT_CH1_N_O)
         |-> (wr_age <= 4'h8);
   endproperty
   a_reset_out: assert property (p_reset_out) else $error("outputs not at reset level");
   a_user0: assert property (p_user0) else $error("user pin 0 off irq enable");
   a_user1: assert property (p_user1) else $error("user pin 1 off irq enable");
   a_irq0: assert property (p_irq0) else $error("irq 0 active while floating");
   a_irq1: assert property (p_irq1) else $error("irq 1 active while floating");
   a_rd_start: assert property (p_rd_start) else $error("bus driven without read");
   a_rd_end: assert property (p_rd_end) else $error("bus not released");
   a_ctl_src: assert property (p_ctl_src) else $error("control pin moved without write");
   c_read: cover property ($fell(HOST_DATA_BUS_OE_N_O));
   c_irq: cover property ($rose(IRQ_CH0_O));
   c_full: cover property ($rose(TX_DMA_REQUEST_N_O[1]));
endmodule // duc_top_props

bind duc_top duc_top_props u_props (.CLK_I(CLK_I), .RESETN_I(RESETN_I),
   .READ_STROBE_N_I(READ_STROBE_N_I), .WRITE_STROBE_N_I(WRITE_STROBE_N_I),
   .CHIP_SELECT_CH0_N_I(CHIP_SELECT_CH0_N_I), .CHIP_SELECT_CH1_N_I(CHIP_SELECT_CH1_N_I),
   .HOST_DATA_BUS_OE_N_O(HOST_DATA_BUS_OE_N_O), .TX_O(TX_O), .DTR_N_O(DTR_N_O),
   .RTS_N_O(RTS_N_O), .USER_OUTPUT_CH0_N_O(USER_OUTPUT_CH0_N_O),
   .USER_OUTPUT_CH1_N_O(USER_OUTPUT_CH1_N_O), .IRQ_CH0_O(IRQ_CH0_O),
   .IRQ_CH0_OE_N_O(IRQ_CH0_OE_N_O), .IRQ_CH1_O(IRQ_CH1_O), .IRQ_CH1_OE_N_O(IRQ_CH1_OE_N_O),
   .RX_DMA_REQUEST_N_O(RX_DMA_REQUEST_N_O), .TX_DMA_REQUEST_N_O(TX_DMA_REQUEST_N_O));

//--- bench/duc_modem_model.sv
// Behavioural modem and link partner for the dual serial channel bench.
`timescale 1ns/10ps
module duc_modem_model #(
   parameter BAUD = 8
) (
   input wire clk_i,
   input wire [1:0] tx_i,
   input wire [7:0] modem_i,
   output wire [1:0] rx_o,
   output wire [7:0] modem_n_o,
   output reg [7:0] byte_o = 8'h00,
   output reg [7:0] count_o = 8'h00
);
   reg [7:0] shift;
   integer i;
   // Each transmit line feeds the other channel's receive line.
   assign rx_o = {tx_i[0], tx_i[1]};
   assign modem_n_o = modem_i;
   // Channel one frames are sampled mid bit, first bit into bit zero.
   always @(negedge tx_i[1]) begin
      repeat (BAUD + BAUD / 2) @(posedge clk_i);
      for (i = 0; i < 8; i = i + 1) begin
         shift[i] = tx_i[1];
         repeat (BAUD) @(posedge clk_i);
      end
      byte_o = shift;
      count_o = count_o + 8'h01;
   end
endmodule // duc_modem_model

//--- bench/duc_top_tb.sv
// Self-checking bench for the dual serial channel top level.
`timescale 1ns/10ps
`include "duc_defines.vh"
`define CHK(nm, ex, got) begin compares = compares + 1; if ((got) !== (ex)) begin \
   n_mismatch = n_mismatch + 1; $display("[ERR] %s expected %h seen %h", nm, ex, got); end end
module duc_top_tb;
   typedef struct {logic ch; logic [7:0] modem_control_register; logic [5:0] pins;} row_t;
   reg clk = 1'b0;
   reg rst_n = 1'b0;
   reg rd_n = 1'b1;
   reg wr_n = 1'b1;
   reg [1:0] cs_n = 2'h3;
   reg [2:0] addr = 3'h0;
   reg [7:0] wdata = 8'h00;
   reg [7:0] modem = 8'hFF;
   reg [7:0] d;
   reg [7:0] base;
   wire [7:0] bus_o, p_byte, p_count, mdm_n;
   wire bus_oe_n, user0_n, user1_n, irq0, irq0_oe_n, irq1, irq1_oe_n;
   wire [1:0] rx, tx, dtr_n, rts_n, rx_req_n, tx_req_n;
   integer n_mismatch = 0;
   integer compares = 0;
   integer cycles = 0;
   integer i, k;
   row_t rows [0:6] = '{'{1'b0, 8'h01, 6'h3E}, '{1'b0, 8'h02, 6'h3B}, '{1'b0, 8'h08, 6'h2F},
      '{1'b1, 8'h03, 6'h25}, '{1'b1, 8'h08, 6'h0F}, '{1'b0, 8'h00, 6'h1F},
      '{1'b1, 8'h00, 6'h3F}};
   always #5 clk = ~clk;
   duc_top #(.BAUD_CYCLES(8), .RX_TIMEOUT_CYCLES(100)) u_dut (.CLK_I(clk), .RESETN_I(rst_n),
      .READ_STROBE_N_I(rd_n), .WRITE_STROBE_N_I(wr_n), .CHIP_SELECT_CH0_N_I(cs_n[0]),
      .CHIP_SELECT_CH1_N_I(cs_n[1]), .REG_SELECT_LINES_I(addr), .HOST_DATA_BUS_I(wdata),
      .HOST_DATA_BUS_O(bus_o), .HOST_DATA_BUS_OE_N_O(bus_oe_n), .RX_I(rx),
      .CTS_N_I(mdm_n[1:0]), .DSR_N_I(mdm_n[3:2]), .RI_N_I(mdm_n[5:4]), .CD_N_I(mdm_n[7:6]),
      .TX_O(tx), .DTR_N_O(dtr_n), .RTS_N_O(rts_n), .USER_OUTPUT_CH0_N_O(user0_n),
      .USER_OUTPUT_CH1_N_O(user1_n), .IRQ_CH0_O(irq0), .IRQ_CH0_OE_N_O(irq0_oe_n),
      .IRQ_CH1_O(irq1), .IRQ_CH1_OE_N_O(irq1_oe_n), .RX_DMA_REQUEST_N_O(rx_req_n),
      .TX_DMA_REQUEST_N_O(tx_req_n));
   duc_modem_model #(.BAUD(8)) u_modem (.clk_i(clk), .tx_i(tx), .modem_i(modem), .rx_o(rx),
      .modem_n_o(mdm_n), .byte_o(p_byte), .count_o(p_count));
   // ****************************************
   // Helpers
   // ****************************************
   function automatic [5:0] pins();
      pins = {user1_n, user0_n, rts_n, dtr_n};
   endfunction
   function automatic [10:0] misc();
      misc = {tx, rx_req_n, tx_req_n, bus_oe_n, irq1_oe_n, irq0_oe_n, irq1, irq0};
   endfunction
   task wr(input logic ch, input logic [2:0] a, input logic [7:0] v);
      begin
         @(posedge clk);
         cs_n <= ch ? 2'h1 : 2'h2;
         addr <= a;
         wdata <= v;
         wr_n <= 1'b0;
         repeat (8) @(posedge clk);
         wr_n <= 1'b1;
         repeat (8) @(posedge clk);
         cs_n <= 2'h3;
      end
   endtask
   task rd(input logic ch, input logic [2:0] a, output logic [7:0] v);
      begin
         @(posedge clk);
         cs_n <= ch ? 2'h1 : 2'h2;
         addr <= a;
         rd_n <= 1'b0;
         repeat (8) @(posedge clk);
         v = bus_o;
         `CHK("bus driven", 1'b0, bus_oe_n)
         rd_n <= 1'b1;
         repeat (8) @(posedge clk);
         cs_n <= 2'h3;
      end
   endtask
   task wait_frames(input integer n);
      integer w;
      begin
         w = 0;
         while (p_count != base + n[7:0] && w < 3000) begin
            @(posedge clk);
            w = w + 1;
         end
         `CHK("frame count", base + n[7:0], p_count)
         repeat (16) @(posedge clk);
      end
   endtask
   task end_sim;
      begin
         $display("compares %0d mismatches %0d", compares, n_mismatch);
         if (n_mismatch == 0 && compares > 0) begin
            $display("bench passed");
         end else begin
            $display("bench failed");
         end
         $finish;
      end
   endtask
   always @(posedge clk) begin
      cycles = cycles + 1;
      if (cycles == 20000) begin
         n_mismatch = n_mismatch + 1;
         end_sim;
      end
   end
   // ****************************************
   // Tests
   // ****************************************
   initial begin
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      `CHK("reset pins", 6'h3F, pins())
      `CHK("reset misc", 11'h79C, misc())
      $display("test reset done");
      for (i = 0; i < 7; i = i + 1) begin
         wr(rows[i].ch, `DUC_OFS_MCR, rows[i].modem_control_register);
         `CHK("modem pins", rows[i].pins, pins())
      end
      $display("test control rows done");
      modem <= 8'hBE;
      repeat (8) @(posedge clk);
      rd(1'b0, `DUC_OFS_MSR, d);
      rd(1'b0, `DUC_OFS_MSR, d);
      `CHK("status cts", 8'h90, d)
      modem <= 8'hBA;
      repeat (8) @(posedge clk);
      rd(1'b0, `DUC_OFS_MSR, d);
      `CHK("status dsr", 8'hB2, d)
      $display("test status done");
      wr(1'b0, `DUC_OFS_IER, 8'h08);
      wr(1'b0, `DUC_OFS_MCR, 8'h08);
      modem <= 8'hAA;
      repeat (8) @(posedge clk);
      `CHK("ring fall irq", 1'b0, irq0)
      modem <= 8'hBA;
      repeat (8) @(posedge clk);
      `CHK("ring rise irq", 2'h1, {irq0_oe_n, irq0})
      rd(1'b0, `DUC_OFS_MSR, d);
      `CHK("status ring", 8'hB4, d)
      `CHK("irq cleared", 1'b0, irq0)
      wr(1'b0, `DUC_OFS_MCR, 8'h00);
      modem <= 8'hAA;
      repeat (8) @(posedge clk);
      modem <= 8'hBA;
      repeat (8) @(posedge clk);
      `CHK("irq floating", 2'h2, {irq0_oe_n, irq0})
      $display("test ring done");
      base = p_count;
      wr(1'b1, `DUC_OFS_DATA, 8'h3C);
      wait_frames(1);
      `CHK("link byte", 8'h3C, p_byte)
      `CHK("rx ready", 1'b0, rx_req_n[0])
      rd(1'b0, `DUC_OFS_DATA, d);
      `CHK("rx byte", 8'h3C, d)
      $display("test serial done");
      wr(1'b1, `DUC_OFS_EFR, 8'h80);
      base = p_count;
      for (i = 0; i < 17; i = i + 1) begin
         wr(1'b1, `DUC_OFS_DATA, 8'h40 + i[7:0]);
      end
      `CHK("tx held full", 2'h3, {tx[1], tx_req_n[1]})
      modem <= 8'hB8;
      wait_frames(16);
      `CHK("tx space", 1'b0, tx_req_n[1])
      for (i = 0; i < 16; i = i + 1) begin
         rd(1'b0, `DUC_OFS_DATA, d);
         `CHK("rx fifo", 8'h40 + i[7:0], d)
      end
      `CHK("rx drained", 1'b1, rx_req_n[0])
      rd(1'b0, `DUC_OFS_DATA, d);
      `CHK("overflow dropped", 8'h00, d)
      $display("test flow done");
      wr(1'b0, `DUC_OFS_TRIG, 8'h12);
      wr(1'b0, `DUC_OFS_FLOW, 8'h01);
      wr(1'b0, `DUC_OFS_EFR, 8'h40);
      wr(1'b0, `DUC_OFS_MCR, 8'h02);
      `CHK("rts on", 1'b0, rts_n[0])
      base = p_count;
      wr(1'b1, `DUC_OFS_DATA, 8'h66);
      wait_frames(1);
      `CHK("rts halted", 1'b1, rts_n[0])
      `CHK("rx below trigger", 1'b1, rx_req_n[0])
      repeat (120) @(posedge clk);
      `CHK("rx timeout ready", 1'b0, rx_req_n[0])
      rd(1'b0, `DUC_OFS_DATA, d);
      `CHK("flow byte", 8'h66, d)
      `CHK("rts resumed", 1'b0, rts_n[0])
      $display("test auto flow done");
      wr(1'b0, `DUC_OFS_MCR, 8'h10);
      wr(1'b1, `DUC_OFS_DATA, 8'h5A);
      wr(1'b0, `DUC_OFS_DATA, 8'hA5);
      k = 0;
      for (i = 0; i < 200; i = i + 1) begin
         @(posedge clk);
         k = k + (tx[0] === 1'b1 ? 0 : 1);
      end
      `CHK("loop tx idle", 0, k)
      rd(1'b0, `DUC_OFS_DATA, d);
      `CHK("loop byte", 8'hA5, d)
      rd(1'b0, `DUC_OFS_DATA, d);
      `CHK("loop pin ignored", 8'h00, d)
      $display("test loopback done");
      rst_n <= 1'b0;
      repeat (3) @(posedge clk);
      `CHK("rerun pins", 6'h3F, pins())
      `CHK("rerun misc", 11'h7FC, misc())
      rst_n <= 1'b1;
      repeat (8) @(posedge clk);
      rd(1'b0, `DUC_OFS_MCR, d);
      `CHK("control cleared", 8'h00, d)
      $display("test second reset done");
      end_sim;
   end
endmodule // duc_top_tb
